// ==== bench/bwp_core_props.sv ====
// Port checker for bwp_core.
// Assumes a bind from the bench top and one core clock.
module bwp_core_props
   import bwp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic async_ready_in,
   input wire logic sync_ready_in,
   input wire logic region_ignore_ready,
   input wire logic internal_sel,
   input wire logic bus_start,
   input wire logic bus_active,
   input wire logic [1:0] bus_kind,
   input wire logic bus_done,
   input wire logic in_wait,
   input wire logic execute_unit_req,
   input wire logic execute_unit_ack,
   input wire logic op_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] hi_reg;
   logic [2:0] lo_reg;
   wire logic rdy = sync_ready_in | async_ready_in;
   wire logic ign = internal_sel | region_ignore_ready;
   // Saturating run lengths; pins reach the decision two flops late
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hi_reg <= 3'h0;
         lo_reg <= 3'h0;
      end else begin
         hi_reg <= !rdy ? 3'h0 : hi_reg + {2'h0, hi_reg != 3'h7};
         lo_reg <= rdy ? 3'h0 : lo_reg + {2'h0, lo_reg != 3'h7};
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   start_t2_a: assert property (
      bus_start |=> bus_active && !bus_start && !in_wait) else $error("no T2");
   ready_ends_a: assert property (
      (bus_start && hi_reg >= 3'h3 && rdy) ##1 rdy [*2] |=> bus_done) else $error("no end");
   both_low_a: assert property (
      (bus_start && !ign && !$past(ign)) ##2 (lo_reg >= 3'h2 && !rdy) |=> in_wait)
      else $error("no wait");
   wait_more_a: assert property (
      in_wait && lo_reg >= 3'h2 && !rdy |=> in_wait) else $error("wait cut");
   ignore_rdy_a: assert property (
      bus_start && ign && $past(ign) |-> ##3 bus_done) else $error("ready not ignored");
   ack_done_a: assert property (
      execute_unit_ack |-> bus_done && bus_kind != 2'h0) else $error("bad ack");
   fetch_yield_a: assert property (
      bus_start && bus_kind == 2'h0 |-> !$past(execute_unit_req) || $past(execute_unit_ack))
      else $error("fetch over request");
   reset_empty_a: assert property (
      $fell(rst) |-> !op_valid [*4]) else $error("queue not empty");
   wait_c: cover property (in_wait ##1 bus_done);
   ack_c: cover property (execute_unit_ack);
   ign_c: cover property (bus_start && ign);
endmodule : bwp_core_props

// ==== bench/bwp_core_tb_top.sv ====
// Bench top for bwp_core: fill, jump and ready scenarios.
// Assumes bwp_mem_model on the bus; checker bound below.
module bwp_core_tb_top;
   import bwp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst, async_ready_in, sync_ready_in, region_ignore_ready, internal_sel;
   logic bus_start, bus_active, bus_word, bus_done, in_wait, execute_unit_req;
   logic execute_unit_ack, execute_unit_jump, op_valid, op_ready, op_is_target;
   logic [ADDR_W-1:0] bus_addr, execute_unit_target;
   logic [15:0] bus_wdata, bus_rdata, execute_unit_rdata;
   logic [1:0] bus_kind, mode;
   logic [7:0] op_byte, waits;
   bwp_req_s execute_unit_cmd;
   int err_count, total_checks, wcnt;
   logic [ADDR_W:0] flog[$];
   bwp_core #(.WIDE_BUS(1'b1)) dut (.core_clk, .rst, .async_ready_in, .sync_ready_in,
      .region_ignore_ready, .internal_sel, .bus_start, .bus_active, .bus_addr, .bus_word,
      .bus_kind, .bus_wdata, .bus_rdata, .bus_done, .in_wait, .execute_unit_req,
      .execute_unit_cmd, .execute_unit_ack, .execute_unit_rdata, .execute_unit_jump,
      .execute_unit_target, .op_valid, .op_ready, .op_byte, .op_is_target);
   bwp_mem_model mem (.core_clk, .bus_start, .bus_active, .bus_addr, .waits, .mode,
      .async_ready_in, .sync_ready_in, .bus_rdata);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (bus_start === 1'b1 && bus_kind === 2'h0)
         flog.push_back({bus_word, bus_addr});
      if (in_wait === 1'b1)
         wcnt++;
   end
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic drain(input logic [7:0] a, input int n);
      int k;
      op_ready = 1'b1;
      for (int i = 0; i < n; i++) begin
         k = 0;
         while (op_valid !== 1'b1 && k < 50) begin
            step(1);
            k++;
         end
         chk(op_byte, a + i[7:0]);
         chk(op_is_target, i == 0);
         step(1);
      end
      op_ready = 1'b0;
   endtask : drain
   task automatic t_fill();
      step(150);
      chk(flog.size(), Q_DEPTH_WIDE / 2);
      chk(flog[0], {1'b1, RESET_PC});
      drain(RESET_PC[7:0], 8);
      $display("fill done");
   endtask : t_fill
   task automatic t_jump();
      step(60);
      execute_unit_target = 20'h00123;
      execute_unit_jump = 1'b1;
      flog.delete();
      step(1);
      execute_unit_jump = 1'b0;
      step(60);
      chk(flog[0], {1'b0, 20'h00123});
      chk(flog[1], {1'b1, 20'h00124});
      drain(8'h23, 4);
      $display("jump done");
   endtask : t_jump
   task automatic t_ready();
      int w[7] = '{12, 40, 12, 12, 12, 12, 3};
      int m[7] = '{0, 0, 1, 2, 0, 0, 0};
      int s[7] = '{0, 0, 0, 0, 1, 2, 0};
      int slow;
      int k;
      for (int i = 0; i < 7; i++) begin
         waits = w[i][7:0];
         mode = m[i][1:0];
         internal_sel = s[i] == 1;
         region_ignore_ready = s[i] == 2;
         execute_unit_cmd = '{20'h00456, 16'hA5C3, i == 6, 1'b0, 1'b0};
         step(20);
         wcnt = 0;
         k = 0;
         execute_unit_req = 1'b1;
         step(1);
         while (execute_unit_ack !== 1'b1 && k < 200) begin
            step(1);
            k++;
         end
         execute_unit_req = 1'b0;
         slow = (m[i] == 0 && s[i] == 0) ? w[i] : 0;
         chk(wcnt >= slow - 4 && wcnt <= slow, 1);
         chk(bus_kind, (i == 6) ? 2 : 1);
         chk(bus_addr, 20'h00456);
         chk(i == 6 ? bus_wdata : execute_unit_rdata, i == 6 ? 16'hA5C3 : 16'h5756);
      end
      $display("ready done");
   endtask : t_ready
   task automatic t_yield();
      int k;
      waits = 8'h00;
      mode = 2'h0;
      execute_unit_cmd = '{20'h00456, 16'h0000, 1'b0, 1'b0, 1'b0};
      flog.delete();
      k = 0;
      execute_unit_req = 1'b1;
      op_ready = 1'b1;
      step(2);
      op_ready = 1'b0;
      while (execute_unit_ack !== 1'b1 && k < 200) begin
         step(1);
         k++;
      end
      execute_unit_req = 1'b0;
      chk(flog.size(), 0);
      step(20);
      chk(flog.size(), 1);
      $display("yield done");
   endtask : t_yield
   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test
   initial begin
      rst = 1'b1;
      region_ignore_ready = 1'b0;
      internal_sel = 1'b0;
      execute_unit_req = 1'b0;
      execute_unit_cmd = '0;
      execute_unit_jump = 1'b0;
      execute_unit_target = ADDR_ZERO;
      op_ready = 1'b0;
      waits = 8'h00;
      mode = 2'h0;
      step(6);
      rst = 1'b0;
      t_fill();
      t_jump();
      t_ready();
      t_yield();
      stop_test();
   end
   initial begin
      #80000;
      err_count++;
      stop_test();
   end
endmodule : bwp_core_tb_top
bind bwp_core bwp_core_props u_props (.core_clk, .rst, .async_ready_in, .sync_ready_in,
   .region_ignore_ready, .internal_sel, .bus_start, .bus_active, .bus_kind, .bus_done,
   .in_wait, .execute_unit_req, .execute_unit_ack, .op_valid);

// ==== bench/bwp_mem_model.sv ====
// Slow local memory: byte at address a reads back a[7:0].
// Assumes bwp_core cycle outputs; ready pins normally high.
module bwp_mem_model
   import bwp_pkg::*;
(
   input wire logic core_clk,
   input wire logic bus_start,
   input wire logic bus_active,
   input wire logic [bwp_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [7:0] waits,
   input wire logic [1:0] mode,
   output logic async_ready_in,
   output logic sync_ready_in,
   output logic [15:0] bus_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_reg;
   wire logic [15:0] word = {bus_addr[7:1], 1'b1, bus_addr[7:1], 1'b0};
   wire logic slow = bus_active && (bus_start || cnt_reg < waits);
   always_ff @(posedge core_clk) cnt_reg <= bus_start ? 8'h01 : cnt_reg + 8'h01;
   // Pins move only after edges, so both edges are clock aligned
   assign sync_ready_in = !(slow && mode != 2'h2);
   assign async_ready_in = !(slow && mode != 2'h1);
   // Released bus shows the inverse, never a stale match
   assign bus_rdata = bus_active ? word : ~word;
endmodule : bwp_mem_model

// ==== design/bwp_core.sv ====
// Bus interface: ready combining, wait states and instruction prefetch queue.
// Assumes one core clock; ready pins come from off chip; memory answers in T3/Tw.
// Operation
// - A wait state is added only when both ready inputs are low.
// - Wait states continue without limit while not ready.
// - Ready inputs are ignored for internal registers and ready-ignore regions.
// - The async ready passes two flip-flops in series.
// - A low latch stage forces not-ready, a high one passes the pin level.
// - Async ready changes outside sampling have no effect.
// - Sync ready is sampled in T3 and each Tw to choose final or wait.
// - Sync ready changes outside sampling change nothing.
// - The wide-bus queue holds six bytes and fetches one word per cycle.
// - Wide-bus fetches start with two bytes free and no execute request.
// - On the wide bus, a jump to an odd address fetches one byte, then even words.
// - The narrow-bus queue holds four bytes, refills at one free, one byte each.
// - The queue holds bytes from consecutive addresses after the current one.
// - A control transfer flushes the queue and fetches from the target.
// - Execute requests suspend prefetch, letting a running fetch finish.
module bwp_core
   import bwp_pkg::*;
#(
   parameter bit WIDE_BUS = 1'b1
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic async_ready_in,
   input wire logic sync_ready_in,
   input wire logic region_ignore_ready,
   input wire logic internal_sel,
   output logic bus_start,
   output logic bus_active,
   output logic [ADDR_W-1:0] bus_addr,
   output logic bus_word,
   output logic [1:0] bus_kind,
   output logic [15:0] bus_wdata,
   input wire logic [15:0] bus_rdata,
   output logic bus_done,
   output logic in_wait,
   input wire logic execute_unit_req,
   input wire bwp_pkg::bwp_req_s execute_unit_cmd,
   output logic execute_unit_ack,
   output logic [15:0] execute_unit_rdata,
   input wire logic execute_unit_jump,
   input wire logic [ADDR_W-1:0] execute_unit_target,
   output logic op_valid,
   input wire logic op_ready,
   output logic [7:0] op_byte,
   output logic op_is_target
);
   import bwp_pkg::*;

   typedef enum logic [2:0] {
      BWP_T1,
      BWP_T2,
      BWP_T3,
      BWP_TW,
      BWP_T4,
      BWP_IDLE
   } bwp_state_e;

   localparam int QCAP = WIDE_BUS ? Q_DEPTH_WIDE : Q_DEPTH_NARROW;
   localparam int NEED = WIDE_BUS ? FREE_WIDE : FREE_NARROW;
   localparam int CW = $clog2(FIFO_DEPTH + 1);

   function automatic logic word_sel(input logic odd);
      word_sel = WIDE_BUS && !odd;
   endfunction : word_sel

   // Bytes one fetch brings; pc step and space check must agree
   function automatic int fetch_len(input logic word);
      fetch_len = word ? BYTES_WORD : BYTES_BYTE;
   endfunction : fetch_len

   // Async ready: resolve flop, then latch; rise and fall both pass the two flops
   logic async_ready_in_resolve_reg;
   logic async_ready_in_latch_reg;
   logic sync_ready_in_s1_reg;
   logic sync_ready_in_reg;
   logic async_ready_in_pin_s1_reg;
   logic async_ready_in_pin_reg;

   bwp_state_e state_reg;
   bwp_state_e state_next;
   bwp_cyc_e kind_reg;
   logic ign_reg;
   logic word_reg;
   logic tgt_pending_reg;
   logic [ADDR_W-1:0] fetch_pc_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rdata_reg;
   logic [7:0] hi_byte_reg;
   logic hi_pend_reg;
   logic hi_tgt_reg;
   logic ack_reg;
   logic flushed_reg;
   logic [CW-1:0] q_count;
   logic fifo_in_ready;
   bwp_cyc_e kind_next;
   logic [ADDR_W-1:0] addr_next;
   logic word_next;
   logic [ADDR_W-1:0] fetch_pc_next;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         async_ready_in_resolve_reg <= 1'b0;
         async_ready_in_latch_reg <= 1'b0;
      end else begin
         async_ready_in_resolve_reg <= async_ready_in;
         async_ready_in_latch_reg <= async_ready_in_resolve_reg;
      end
   end

   // Pin level seen past the latch also crosses two flops
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         async_ready_in_pin_s1_reg <= 1'b0;
         async_ready_in_pin_reg <= 1'b0;
      end else begin
         async_ready_in_pin_s1_reg <= async_ready_in;
         async_ready_in_pin_reg <= async_ready_in_pin_s1_reg;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync_ready_in_s1_reg <= 1'b0;
         sync_ready_in_reg <= 1'b0;
      end else begin
         sync_ready_in_s1_reg <= sync_ready_in;
         sync_ready_in_reg <= sync_ready_in_s1_reg;
      end
   end

   // Latched low forces not-ready; latched high passes the (synchronised) pin level
   wire async_ready_in_eff = async_ready_in_latch_reg && async_ready_in_pin_reg;
   wire ready_any = async_ready_in_eff || sync_ready_in_reg;
   // Ready only looked at in T3/Tw; other edges are don't-care
   wire sample_pt = (state_reg == BWP_T3) || (state_reg == BWP_TW);
   wire go_final = ign_reg || ready_any;

   // Free space counts the queue plus a held high byte and an in-flight fetch
   wire [CW-1:0] held = CW'(hi_pend_reg);
   wire fetch_busy = bus_active && (kind_reg == BWP_CYC_FETCH) && !flushed_reg;
   // Bytes of the running fetch not yet queued; leaving them out overfills
   wire [CW-1:0] in_flight = fetch_busy ? CW'(fetch_len(word_reg)) : '0;
   wire [CW-1:0] used = q_count + held + in_flight;
   wire [CW-1:0] free_bytes = (used >= CW'(QCAP)) ? '0 : CW'(QCAP) - used;
   wire fetch_ok = (free_bytes >= CW'(NEED)) && !execute_unit_req;
   wire odd_fetch = fetch_pc_reg[0];
   wire idle_like = (state_reg == BWP_IDLE) || (state_reg == BWP_T4);
   wire start_ex = idle_like && execute_unit_req && !execute_unit_jump;
   wire start_fetch = idle_like && !execute_unit_req && fetch_ok && !execute_unit_jump;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         BWP_IDLE, BWP_T4: begin
            state_next = (start_ex || start_fetch) ? BWP_T1 : BWP_IDLE;
         end
         BWP_T1: state_next = BWP_T2;
         BWP_T2: state_next = BWP_T3;
         BWP_T3, BWP_TW: begin
            state_next = go_final ? BWP_T4 : BWP_TW;
         end
         default: state_next = BWP_IDLE;
      endcase
   end

   // Cycle attributes load only at launch and stand for the whole cycle
   wire launch = start_ex || start_fetch;
   wire cycle_end = sample_pt && go_final;
   assign kind_next = !start_ex ? BWP_CYC_FETCH
      : (execute_unit_cmd.write ? BWP_CYC_WRITE : BWP_CYC_READ);
   assign addr_next = start_ex ? execute_unit_cmd.addr : fetch_pc_reg;
   assign word_next = start_ex ? WIDE_BUS : word_sel(odd_fetch);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= BWP_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         kind_reg <= BWP_CYC_FETCH;
      end else if (launch) begin
         kind_reg <= kind_next;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         addr_reg <= ADDR_ZERO;
      end else if (launch) begin
         addr_reg <= addr_next;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         word_reg <= 1'b0;
      end else if (launch) begin
         word_reg <= word_next;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ign_reg <= 1'b0;
      end else if (launch) begin
         ign_reg <= internal_sel || region_ignore_ready;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wdata_reg <= DATA_ZERO;
      end else if (start_ex) begin
         wdata_reg <= execute_unit_cmd.wdata;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= DATA_ZERO;
      end else if (cycle_end) begin
         rdata_reg <= bus_rdata;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= cycle_end && (kind_reg != BWP_CYC_FETCH);
      end
   end

   // Bytes from a completed fetch; flushed fetch data is dropped silently
   wire fetch_done = (state_reg == BWP_T4) && (kind_reg == BWP_CYC_FETCH) && !flushed_reg;
   wire push_lo = fetch_done && !hi_pend_reg;
   wire push_hi = hi_pend_reg;
   wire fifo_push = (push_lo || push_hi) && !execute_unit_jump;
   bwp_qbyte_s push_byte;
   assign push_byte.data = push_hi ? hi_byte_reg
      : (addr_reg[0] ? rdata_reg[15:8] : rdata_reg[7:0]);
   assign push_byte.target = push_hi ? hi_tgt_reg : tgt_pending_reg;

   wire lo_taken = push_lo && fifo_in_ready;
   wire hi_taken = push_hi && fifo_in_ready;
   wire hi_load = lo_taken && word_reg && !execute_unit_jump;
   assign fetch_pc_next = fetch_pc_reg + ADDR_W'(fetch_len(word_sel(odd_fetch)));

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fetch_pc_reg <= RESET_PC;
      end else if (execute_unit_jump) begin
         fetch_pc_reg <= execute_unit_target;
      end else if (start_fetch) begin
         fetch_pc_reg <= fetch_pc_next;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tgt_pending_reg <= 1'b1;
      end else if (execute_unit_jump) begin
         tgt_pending_reg <= 1'b1;
      end else if (lo_taken) begin
         tgt_pending_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hi_byte_reg <= 8'h00;
      end else if (hi_load) begin
         hi_byte_reg <= rdata_reg[15:8];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hi_tgt_reg <= 1'b0;
      end else if (hi_load) begin
         hi_tgt_reg <= 1'b0;
      end
   end

   // A new high byte wins over the drain of the old one
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hi_pend_reg <= 1'b0;
      end else if (execute_unit_jump) begin
         hi_pend_reg <= 1'b0;
      end else if (hi_load) begin
         hi_pend_reg <= 1'b1;
      end else if (hi_taken) begin
         hi_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flushed_reg <= 1'b0;
      end else if (execute_unit_jump) begin
         flushed_reg <= !idle_like || start_fetch;
      end else if (state_reg == BWP_T4) begin
         flushed_reg <= 1'b0;
      end
   end

   // Queue storage; reset and jump empty it
   bwp_fifo #(
      .WIDTH($bits(bwp_qbyte_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_queue (
      .clk(core_clk),
      .rst(rst),
      .flush(execute_unit_jump),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(push_byte),
      .out_valid(op_valid),
      .out_ready(op_ready && !execute_unit_jump),
      .out_data({op_byte, op_is_target}),
      .count(q_count)
   );

   assign bus_start = (state_reg == BWP_T1);
   assign bus_active = (state_reg != BWP_IDLE);
   assign bus_addr = addr_reg;
   assign bus_word = word_reg;
   assign bus_kind = kind_reg;
   assign bus_wdata = wdata_reg;
   assign bus_done = (state_reg == BWP_T4);
   assign in_wait = (state_reg == BWP_TW);
   assign execute_unit_ack = ack_reg;
   assign execute_unit_rdata = rdata_reg;
endmodule : bwp_core

// ==== design/bwp_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock; flush drops all content in one cycle.
module bwp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] count
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [CW-1:0] cnt_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : bump

   assign in_ready = (cnt_reg != CW'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rd_reg];
   assign count = cnt_reg;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else if (flush) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) wr_reg <= bump(wr_reg);
         if (pop) rd_reg <= bump(rd_reg);
         cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
      end
   end
endmodule : bwp_fifo

// ==== shared/bwp_pkg.sv ====
// Package for the bus wait-state and prefetch block: constants, cycle kinds, carriers.
// Assumes one clock domain; all users import bwp_pkg::*.
package bwp_pkg;
   localparam int ADDR_W = 20;
   localparam int Q_DEPTH_WIDE = 6;
   localparam int Q_DEPTH_NARROW = 4;
   localparam int FREE_WIDE = 2;
   localparam int FREE_NARROW = 1;
   localparam int FIFO_DEPTH = 8;
   localparam int BYTES_WORD = 2;
   localparam int BYTES_BYTE = 1;
   localparam logic [ADDR_W-1:0] RESET_PC = 20'hFFFF0;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 20'h00000;
   localparam logic [15:0] DATA_ZERO = 16'h0000;

   typedef enum logic [1:0] {
      BWP_CYC_FETCH,
      BWP_CYC_READ,
      BWP_CYC_WRITE
   } bwp_cyc_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [15:0] wdata;
      logic write;
      logic io;
      logic ignore_ready;
   } bwp_req_s;

   typedef struct packed {
      logic [7:0] data;
      logic target;
   } bwp_qbyte_s;
endpackage : bwp_pkg
